/* design/dbg_trigger_status.sv */
// trigger selection, run status and register port of the bus-watch debug block
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE_01) trigger configuration always readable, writable only while not armed
// (RULE_02) configuration bits 4 and 5 read zero and ignore writes
// (RULE_03) tag type waits for opcode execution; force triggers on any access
// (RULE_04) begin select 0 is end trace, 1 is begin trace
// (RULE_05) event-only modes always run as begin trace
// (RULE_06) modes 0000 A, 0001 A or B, 0010 A then B
// (RULE_07) 0011 stores each B event; 0100 does so after A first
// (RULE_08) 0101 address A and data B; 0110 address A and data not B
// (RULE_09) 0111 inside A..B, 1000 outside, 1001-1111 never trigger
// (RULE_10) A flag clears at run start, sets on A match while armed
// (RULE_11) B flag clears at run start, sets on B match while armed
// (RULE_12) armed flag mirrors arm bit while enabled, set by writing arm
// (RULE_13) run completes on full in begin trace or trigger in end trace
// (RULE_14) writing 0 to arm or enable ends the run at once
// (RULE_15) valid count clears at start, shows 0..8 words at run end
// (RULE_16) valid count never decrements on readout; host tallies reads
// (RULE_17) status register is read-only, writes change nothing
// (RULE_18) arm bit set by write, cleared by run completion
// (RULE_19) configuration write while armed is silently dropped
module dbg_trigger_status
	import dbg_trig_pkg::*;
(
	input wire logic mclk, // core clock, 125 MHz
	input wire logic rst_n, // sync reset, active low
	input wire logic ce, // clock enable, freezes all state
	input wire logic [2:0] reg_addr, // register index
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic acc_valid, // bus access this cycle
	input wire logic cmp_a_hit, // comparator a address match
	input wire logic cmp_b_hit, // comparator b match
	input wire logic addr_ge_a, // access address >= a
	input wire logic addr_le_b, // access address <= b
	input wire logic exec_strobe, // tracked opcode executes
	input wire logic exec_flush, // tracked opcode discarded
	output logic store_req, // store access into fifo, pulse
	output logic trig_pulse, // trigger event, pulse
	output logic run_active, // run armed, level
	output logic irq // interrupt, level
);
	// register index decode, used for both strobes
	function automatic logic sel(input logic [2:0] a, input logic [2:0] ofs);
		sel = (a == ofs);
	endfunction

	qual_if qi ();

	logic [7:0] cfg_ff, ctrl_ff, irq_st_ff, irq_mask_ff, rdata_ff;
	logic af_ff, bf_ff, a_seen_ff, began_ff;
	logic [3:0] words_ff, cnt_ff;
	logic store_ff, trig_ff, irq_ff;
	logic [7:0] nxt_cfg, nxt_ctrl, nxt_irq_st, nxt_rdata, status_val;
	logic [3:0] nxt_words, nxt_cnt;
	logic wr_cfg, wr_ctrl, wr_irq_st, wr_mask;
	logic arm_bit, en_bit, wr_arm, run_start, manual_stop, auto_done, run_end;
	logic event_only, begin_eff, a_q, b_q, trig_q, store_now, in_range, trig_raw;
	trig_mode_t mode;

	// write decode; the status register has no write path
	assign wr_cfg = reg_wr & sel(reg_addr, OFS_TRIG_CFG);
	assign wr_ctrl = reg_wr & sel(reg_addr, OFS_CONTROL);
	assign wr_irq_st = reg_wr & sel(reg_addr, OFS_IRQ_STATUS);
	assign wr_mask = reg_wr & sel(reg_addr, OFS_IRQ_MASK); // RULE_17

	assign arm_bit = ctrl_ff[CTRL_ARM_BIT];
	assign en_bit = ctrl_ff[CTRL_EN_BIT];
	assign mode = trig_mode_t'(cfg_ff[CFG_MODE_LSB +: 4]);

	// config held while armed, reserved bits forced low
	assign nxt_cfg = (wr_cfg && !arm_bit) ? (reg_wdata & CFG_WRITABLE) : cfg_ff; // RULE_01 RULE_02 RULE_19

	// run control: arm needs enable; zero on either ends the run
	assign wr_arm = wr_ctrl & reg_wdata[CTRL_ARM_BIT] & reg_wdata[CTRL_EN_BIT];
	assign run_start = wr_arm & ~arm_bit; // RULE_18
	assign manual_stop = arm_bit & wr_ctrl & ~wr_arm; // RULE_14
	assign run_end = manual_stop | auto_done;

	// arm clears on completion; a rewrite of arm while running keeps the run going
	always_comb begin
		nxt_ctrl = reg_wdata;
		if (!wr_ctrl) begin
			nxt_ctrl = ctrl_ff;
		end
		nxt_ctrl[CTRL_ARM_BIT] = wr_ctrl ? wr_arm : arm_bit;
		if (auto_done && !(wr_ctrl && run_start)) begin
			nxt_ctrl[CTRL_ARM_BIT] = 1'b0; // RULE_13 RULE_18
		end
	end

	// trigger conditions on the raw access
	assign in_range = addr_ge_a & addr_le_b;
	always_comb begin
		trig_raw = 1'b0;
		unique case (mode)
			MODE_A_ONLY: trig_raw = cmp_a_hit; // RULE_06
			MODE_A_OR_B: trig_raw = cmp_a_hit | cmp_b_hit; // RULE_06
			MODE_A_THEN_B: trig_raw = cmp_b_hit & a_seen_ff; // RULE_06
			MODE_EVENT_B: trig_raw = cmp_b_hit; // RULE_07
			MODE_A_THEN_EVENT_B: trig_raw = cmp_b_hit & a_seen_ff; // RULE_07
			MODE_A_AND_B: trig_raw = cmp_a_hit & cmp_b_hit; // RULE_08
			MODE_A_AND_NOT_B: trig_raw = cmp_a_hit & ~cmp_b_hit; // RULE_08
			MODE_INSIDE: trig_raw = in_range; // RULE_09
			MODE_OUTSIDE: trig_raw = ~in_range; // RULE_09
			default: trig_raw = 1'b0; // RULE_09
		endcase
	end

	// qualifier lanes; events count only while armed
	assign qi.raw_hit[LANE_A] = acc_valid & cmp_a_hit;
	assign qi.raw_hit[LANE_B] = acc_valid & cmp_b_hit;
	assign qi.raw_hit[LANE_TRIG] = acc_valid & trig_raw;
	assign qi.tag_mode = cfg_ff[CFG_TAG_BIT]; // RULE_03
	assign a_q = arm_bit & qi.evt[LANE_A];
	assign b_q = arm_bit & qi.evt[LANE_B];
	assign trig_q = arm_bit & qi.evt[LANE_TRIG];

	match_qualifier u_qual (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.exec_strobe(exec_strobe),
		.exec_flush(exec_flush),
		.q(qi.qual)
	);

	// trace direction; event-only modes ignore the begin select
	assign event_only = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
	assign begin_eff = cfg_ff[CFG_BEGIN_BIT] | event_only; // RULE_04 RULE_05

	// end trace stores every access, begin trace from the trigger on, event-only per event
	assign store_now = arm_bit & (event_only ? trig_q
		: (begin_eff ? acc_valid & (began_ff | trig_q) : acc_valid)); // RULE_04 RULE_07
	// end trace wraps the fifo, so the count saturates at its depth
	assign nxt_words = (store_now && words_ff != FIFO_WORDS) ? words_ff + 4'h1 : words_ff;
	assign auto_done = arm_bit & (begin_eff ? (nxt_words == FIFO_WORDS && store_now) : trig_q); // RULE_13

	// count published only at run end; readout never touches it
	assign nxt_cnt = run_start ? 4'h0 : (run_end ? nxt_words : cnt_ff); // RULE_15 RULE_16

	// status image; armed mirrors arm, which never stands without enable
	always_comb begin
		status_val = 8'h00;
		status_val[STS_A_BIT] = af_ff; // RULE_10
		status_val[STS_B_BIT] = bf_ff; // RULE_11
		status_val[STS_ARMED_BIT] = arm_bit & en_bit; // RULE_12
		status_val[STS_CNT_LSB +: 4] = cnt_ff; // RULE_15
	end

	// read mux; unmapped indices read zero
	assign nxt_rdata = !reg_rd ? 8'h00
		: sel(reg_addr, OFS_TRIG_CFG) ? cfg_ff
		: sel(reg_addr, OFS_RUN_STATUS) ? status_val
		: sel(reg_addr, OFS_CONTROL) ? ctrl_ff
		: sel(reg_addr, OFS_IRQ_STATUS) ? irq_st_ff
		: sel(reg_addr, OFS_IRQ_MASK) ? irq_mask_ff : 8'h00;

	// sticky events: a new event beats a same-cycle clear
	always_comb begin
		nxt_irq_st = wr_irq_st ? (irq_st_ff & ~reg_wdata) : irq_st_ff;
		nxt_irq_st[IRQ_DONE_BIT] = nxt_irq_st[IRQ_DONE_BIT] | run_end;
		nxt_irq_st[IRQ_TRIG_BIT] = nxt_irq_st[IRQ_TRIG_BIT] | trig_q;
	end

	// register file
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_ff <= RST_TRIG_CFG;
			ctrl_ff <= RST_CONTROL;
			irq_st_ff <= 8'h00;
			irq_mask_ff <= RST_IRQ_MASK;
			rdata_ff <= 8'h00;
		end else if (ce) begin
			cfg_ff <= nxt_cfg;
			ctrl_ff <= nxt_ctrl;
			irq_st_ff <= nxt_irq_st;
			irq_mask_ff <= wr_mask ? (reg_wdata & IRQ_USED) : irq_mask_ff;
			rdata_ff <= nxt_rdata;
		end
	end

	// run state, all cleared at run start
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			af_ff <= 1'b0;
			bf_ff <= 1'b0;
			a_seen_ff <= 1'b0;
			began_ff <= 1'b0;
			words_ff <= 4'h0;
			cnt_ff <= 4'h0;
		end else if (ce) begin
			af_ff <= ~run_start & (af_ff | a_q); // RULE_10
			bf_ff <= ~run_start & (bf_ff | b_q); // RULE_11
			a_seen_ff <= ~run_start & (a_seen_ff | a_q); // RULE_06
			began_ff <= ~run_start & ~run_end & (began_ff | (trig_q & begin_eff));
			words_ff <= run_start ? 4'h0 : nxt_words;
			cnt_ff <= nxt_cnt; // RULE_15
		end
	end

	// outputs straight from flops
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			store_ff <= 1'b0;
			trig_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (ce) begin
			store_ff <= store_now;
			trig_ff <= trig_q;
			irq_ff <= |(nxt_irq_st & irq_mask_ff);
		end
	end

	assign reg_rdata = rdata_ff;
	assign store_req = store_ff;
	assign trig_pulse = trig_ff;
	assign run_active = arm_bit;
	assign irq = irq_ff;

	// checks
	default clocking dflt_cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_CFG_LOCK: assert property (ce && arm_bit |=> $stable(cfg_ff)) // RULE_01
		else $error("config changed while armed");
	AST_CFG_RSVD: assert property (cfg_ff[5:4] == 2'b00) // RULE_02
		else $error("reserved config bits set");
	AST_CFG_WRITE: assert property (ce && wr_cfg && !arm_bit |=> cfg_ff == ($past(reg_wdata) & CFG_WRITABLE)) // RULE_01
		else $error("config write lost while idle");
	AST_TAG_WAIT: assert property (qi.tag_mode && !exec_strobe |-> qi.evt == '0) // RULE_03
		else $error("tag event without execution");
	AST_NO_TRIG_MODE: assert property (cfg_ff[3:0] > 4'h8 |-> !trig_raw) // RULE_09
		else $error("reserved mode triggered");
	AST_END_TRACE_DONE: assert property (ce && arm_bit && !begin_eff && trig_q && !wr_ctrl |=> !arm_bit) // RULE_13
		else $error("end trace did not finish on trigger");
	AST_STOP: assert property (ce && arm_bit && wr_ctrl && !reg_wdata[CTRL_EN_BIT] // RULE_14
		|=> !arm_bit && !status_val[STS_ARMED_BIT])
		else $error("manual stop ignored");
	AST_START_CLEAR: assert property (ce && run_start // RULE_10 RULE_11 RULE_15
		|=> !af_ff && !bf_ff && cnt_ff == 4'h0 && arm_bit)
		else $error("run start did not clear status");
	AST_A_FLAG: assert property (ce && a_q |=> af_ff) // RULE_10
		else $error("a flag missed");
	AST_B_FLAG: assert property (ce && b_q && !run_start |=> bf_ff) // RULE_11
		else $error("b flag missed");
	AST_CNT_HOLD: assert property (ce && !run_start && !run_end |=> $stable(cnt_ff)) // RULE_16
		else $error("count moved mid run");
	AST_CNT_MAX: assert property (cnt_ff <= FIFO_WORDS) // RULE_15
		else $error("count above depth");
	AST_STATUS_RO: assert property (ce && reg_wr && sel(reg_addr, OFS_RUN_STATUS) && !arm_bit // RULE_17
		|=> $stable(status_val))
		else $error("status changed by write");
	AST_ARM_SET: assert property (ce && wr_arm |=> status_val[STS_ARMED_BIT] || $past(auto_done)) // RULE_12 RULE_18
		else $error("arm write did not set armed flag");
	AST_EVONLY_BEGIN: assert property (event_only |-> begin_eff) // RULE_05
		else $error("event-only run not begin trace");
	AST_ARM_NEEDS_EN: assert property (arm_bit |-> en_bit) // RULE_12
		else $error("armed without enable");

	// register port: data only in the cycle after a read strobe
	AST_RDATA_IDLE: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	AST_RDATA_CFG: assert property (ce && reg_rd && sel(reg_addr, OFS_TRIG_CFG) // RULE_01
		|=> reg_rdata == $past(cfg_ff))
		else $error("config read back wrong");
	AST_RDATA_STS: assert property (ce && reg_rd && sel(reg_addr, OFS_RUN_STATUS) // RULE_17
		|=> reg_rdata == $past(status_val))
		else $error("status read back wrong");

	// force-type trigger table, seen at the registered pulse
	AST_FORCE_A: assert property (ce && arm_bit && !qi.tag_mode && mode == MODE_A_ONLY // RULE_06
		&& acc_valid && cmp_a_hit |=> trig_pulse)
		else $error("a-only match missed");
	AST_OR_MODE: assert property (ce && arm_bit && !qi.tag_mode && mode == MODE_A_OR_B // RULE_06
		&& acc_valid && (cmp_a_hit || cmp_b_hit) |=> trig_pulse)
		else $error("a-or-b match missed");
	AST_B_BEFORE_A: assert property (ce && arm_bit && !qi.tag_mode && mode == MODE_A_THEN_B // RULE_06
		&& !a_seen_ff |=> !trig_pulse)
		else $error("b triggered before any a");
	AST_AND_MODE: assert property (ce && arm_bit && !qi.tag_mode && mode == MODE_A_AND_B // RULE_08
		&& acc_valid && cmp_a_hit && cmp_b_hit |=> trig_pulse)
		else $error("a-and-b match missed");
	AST_AND_NOT: assert property (ce && !qi.tag_mode && mode == MODE_A_AND_NOT_B && cmp_b_hit // RULE_08
		|=> !trig_pulse)
		else $error("a-and-not-b fired on data match");
	AST_INSIDE: assert property (ce && arm_bit && !qi.tag_mode && mode == MODE_INSIDE // RULE_09
		&& acc_valid && addr_ge_a && addr_le_b |=> trig_pulse)
		else $error("inside range missed");
	AST_OUTSIDE_IN: assert property (ce && !qi.tag_mode && mode == MODE_OUTSIDE // RULE_09
		&& addr_ge_a && addr_le_b |=> !trig_pulse)
		else $error("outside mode fired inside range");

	// qualifier: force passes at once, tag fires on the execute strobe
	AST_FORCE_PASS: assert property (!qi.tag_mode |-> qi.evt == qi.raw_hit) // RULE_03
		else $error("force match not passed through");
	AST_TAG_PEND: assert property (ce && qi.tag_mode && qi.raw_hit[LANE_TRIG] // RULE_03
		##1 qi.tag_mode && exec_strobe |-> qi.evt[LANE_TRIG])
		else $error("executed tag match lost");

	// storage and completion
	AST_EVENT_STORE: assert property (ce && event_only && trig_q |=> store_req) // RULE_07
		else $error("event not stored");
	AST_QUIET_IDLE: assert property (ce && !arm_bit |=> !store_req && !trig_pulse) // RULE_12
		else $error("activity while disarmed");
	AST_BEGIN_WAIT: assert property (ce && arm_bit && begin_eff && !event_only && !began_ff && !trig_q // RULE_04
		|=> !store_req)
		else $error("begin trace stored before trigger");
	AST_END_STORE: assert property (ce && arm_bit && !begin_eff && acc_valid |=> store_req) // RULE_04
		else $error("end trace access not stored");
	AST_BEGIN_FULL: assert property (ce && arm_bit && begin_eff && store_now && nxt_words == FIFO_WORDS // RULE_13
		|=> !arm_bit)
		else $error("begin trace did not finish when full");
	AST_ARM_ZERO_STOP: assert property (ce && arm_bit && wr_ctrl && !reg_wdata[CTRL_ARM_BIT] // RULE_14
		|=> !arm_bit)
		else $error("arm clear ignored");
	AST_CNT_RUN: assert property (ce && arm_bit && !run_end |=> cnt_ff == 4'h0) // RULE_15
		else $error("count shown during run");
	AST_FLAGS_IDLE: assert property (ce && !arm_bit && !run_start // RULE_10 RULE_11
		|=> $stable(af_ff) && $stable(bf_ff))
		else $error("match flag moved while disarmed");
	AST_DONE_STICKY: assert property (ce && run_end |=> irq_st_ff[IRQ_DONE_BIT]) // RULE_13
		else $error("run end event lost");

	// clock enable low freezes control, config, count, read data and irq
	AST_CE_FREEZE: assert property (!ce |=> $stable(ctrl_ff) && $stable(cfg_ff) && $stable(cnt_ff)
		&& $stable(reg_rdata) && $stable(irq))
		else $error("state moved with clock enable low");

	COV_END_TRACE: cover property (arm_bit && !begin_eff && trig_q ##1 !arm_bit);
	COV_BEGIN_FULL: cover property (arm_bit && begin_eff && auto_done);
	COV_A_THEN_B: cover property (mode == MODE_A_THEN_B && a_q ##[1:20] trig_q);
	COV_IRQ: cover property (!irq ##1 irq);
	COV_TAG_EXEC: cover property (qi.tag_mode && trig_q);
endmodule
`default_nettype wire

/* design/match_qualifier.sv */
// opcode tracking qualifier for comparator and trigger matches
`timescale 1ns/1ps
`default_nettype none
module match_qualifier
	import dbg_trig_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic rst_n, // sync reset, active low
	input wire logic ce, // clock enable
	input wire logic exec_strobe, // tracked opcode executes
	input wire logic exec_flush, // tracked opcode discarded
	qual_if.qual q // lanes to the core
);
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic pend_ff;
			logic nxt_pend;
			// force passes the access match, tag waits for the opcode to execute
			assign q.evt[g] = q.tag_mode ? (pend_ff & exec_strobe) : q.raw_hit[g]; // RULE_03
			// a new match replaces the pending one; flush drops it
			assign nxt_pend = q.raw_hit[g] | (pend_ff & ~exec_strobe & ~exec_flush);
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					pend_ff <= 1'b0;
				end else if (ce) begin
					pend_ff <= q.tag_mode & nxt_pend;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* include/dbg_trig_pkg.sv */
// constants and types shared by the trigger and run-status logic
package dbg_trig_pkg;
	// register map, word index on the plain register port
	localparam logic [2:0] OFS_TRIG_CFG = 3'h0;
	localparam logic [2:0] OFS_RUN_STATUS = 3'h1;
	localparam logic [2:0] OFS_CONTROL = 3'h2;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h3;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h4;
	// trigger configuration fields
	localparam int CFG_TAG_BIT = 7;
	localparam int CFG_BEGIN_BIT = 6;
	localparam int CFG_MODE_LSB = 0;
	localparam logic [7:0] CFG_WRITABLE = 8'hCF;
	// run status fields
	localparam int STS_A_BIT = 7;
	localparam int STS_B_BIT = 6;
	localparam int STS_ARMED_BIT = 5;
	localparam int STS_CNT_LSB = 0;
	// control fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_ARM_BIT = 6;
	// interrupt status fields
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_TRIG_BIT = 1;
	localparam logic [7:0] IRQ_USED = 8'h03;
	// reset values
	localparam logic [7:0] RST_TRIG_CFG = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	// capture depth in words
	localparam logic [3:0] FIFO_WORDS = 4'h8;
	// qualifier lanes: comparator a, comparator b, combined trigger
	localparam int LANES = 3;
	localparam int LANE_A = 0;
	localparam int LANE_B = 1;
	localparam int LANE_TRIG = 2;

	typedef enum logic [3:0] {
		MODE_A_ONLY = 4'b0000,
		MODE_A_OR_B = 4'b0001,
		MODE_A_THEN_B = 4'b0010,
		MODE_EVENT_B = 4'b0011,
		MODE_A_THEN_EVENT_B = 4'b0100,
		MODE_A_AND_B = 4'b0101,
		MODE_A_AND_NOT_B = 4'b0110,
		MODE_INSIDE = 4'b0111,
		MODE_OUTSIDE = 4'b1000
	} trig_mode_t;
endpackage

/* include/qual_if.sv */
// match lanes between the trigger core and the opcode qualifier
`timescale 1ns/1ps
`default_nettype none
interface qual_if;
	import dbg_trig_pkg::*;
	logic [LANES-1:0] raw_hit; // unqualified matches of this access
	logic [LANES-1:0] evt; // qualified events
	logic tag_mode; // 1: wait for opcode execution
	modport core (output raw_hit, output tag_mode, input evt);
	modport qual (input raw_hit, input tag_mode, output evt);
endinterface
`default_nettype wire

/* tb/dbg_trigger_status_test.sv */
// self-checking bench for the trigger selection and run-status block
`timescale 1ns/1ps
`default_nettype none
module dbg_trigger_status_test
	import dbg_trig_pkg::*;
;
	logic mclk, rst_n, ce, reg_wr, reg_rd, acc_valid, cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b;
	logic exec_strobe, exec_flush, store_req, trig_pulse, run_active, irq, tp, sr;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [7:0] tv [10] = '{8'h08, 8'h14, 8'h5C, 8'h6C, 8'h68, 8'h73, 8'h83, 8'h81, 8'h9F, 8'hFF};
	logic ex [10] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;

	dbg_trigger_status DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid), .cmp_a_hit(cmp_a_hit),
		.cmp_b_hit(cmp_b_hit), .addr_ge_a(addr_ge_a), .addr_le_b(addr_le_b), .exec_strobe(exec_strobe),
		.exec_flush(exec_flush), .store_req(store_req), .trig_pulse(trig_pulse), .run_active(run_active), .irq(irq));

	// 125 MHz core clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic complete_run();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard, the whole sequence needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, exp, d);
	endtask

	// one bus access, then sample the registered pulses that answer it
	task automatic acc(input logic [3:0] h, output logic t, output logic s);
		@(posedge mclk);
		acc_valid <= 1'b1;
		{cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} <= h;
		@(posedge mclk);
		acc_valid <= 1'b0;
		{cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} <= 4'h0;
		#1 t = trig_pulse;
		s = store_req;
	endtask

	task automatic exec(input logic flush, output logic t);
		@(posedge mclk);
		exec_strobe <= ~flush;
		exec_flush <= flush;
		@(posedge mclk);
		exec_strobe <= 1'b0;
		exec_flush <= 1'b0;
		#1 t = trig_pulse;
	endtask

	task automatic arm(input logic [7:0] cfg);
		wr(OFS_TRIG_CFG, cfg);
		wr(OFS_CONTROL, 8'hC0);
	endtask

	initial begin
		{rst_n, reg_wr, reg_rd, acc_valid, cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} = 8'h00;
		{exec_strobe, exec_flush} = 2'b00;
		ce = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		// reset values and an unmapped index
		rchk("cfg", OFS_TRIG_CFG, RST_TRIG_CFG);
		rchk("status", OFS_RUN_STATUS, 8'h00);
		rchk("control", OFS_CONTROL, RST_CONTROL);
		rchk("irq_mask", OFS_IRQ_MASK, RST_IRQ_MASK);
		rchk("unmapped", 3'h5, 8'h00);
		wr(OFS_TRIG_CFG, 8'hFF);
		rchk("cfg bits 5:4", OFS_TRIG_CFG, 8'hCF);
		wr(OFS_RUN_STATUS, 8'hFF);
		rchk("status write", OFS_RUN_STATUS, 8'h00);
		// end trace, mode a only, force
		arm(8'h00);
		#1 chk("run_active", 8'h01, {7'h0, run_active});
		rchk("armed flag", OFS_RUN_STATUS, 8'h20);
		wr(OFS_TRIG_CFG, 8'h47);
		rchk("cfg armed", OFS_TRIG_CFG, 8'h00);
		repeat (3) acc(4'h0, tp, sr);
		acc(4'h8, tp, sr);
		chk("end trig", 8'h01, {7'h0, tp});
		repeat (2) @(posedge mclk);
		chk("run end", 8'h00, {7'h0, run_active});
		rchk("status end", OFS_RUN_STATUS, 8'h84);
		rchk("status again", OFS_RUN_STATUS, 8'h84);
		rchk("control end", OFS_CONTROL, 8'h80);
		// interrupt: masked, unmasked, cleared bit by bit
		rchk("irq status", OFS_IRQ_STATUS, IRQ_USED);
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(OFS_IRQ_MASK, IRQ_USED);
		repeat (2) @(posedge mclk);
		chk("irq up", 8'h01, {7'h0, irq});
		wr(OFS_IRQ_STATUS, 8'h01);
		rchk("irq clr0", OFS_IRQ_STATUS, 8'h02);
		wr(OFS_IRQ_STATUS, 8'h02);
		repeat (2) @(posedge mclk);
		chk("irq down", 8'h00, {7'h0, irq});
		// manual stop by clearing arm, new run clears flags
		arm(8'h00);
		rchk("restart", OFS_RUN_STATUS, 8'h20);
		wr(OFS_CONTROL, 8'h80);
		@(posedge mclk);
		chk("manual stop", 8'h00, {7'h0, run_active});
		// single-access mode table, end trace
		for (int i = 0; i < 10; i++) begin
			arm({4'h0, tv[i][7:4]});
			acc(tv[i][3:0], tp, sr);
			chk($sformatf("mode %0d", i), {7'h0, ex[i]}, {7'h0, tp});
			wr(OFS_CONTROL, 8'h00);
		end
		// a then b: b must come after a
		arm(8'h02);
		acc(4'h4, tp, sr);
		acc(4'h8, tp, sr);
		chk("a then b early", 8'h00, {7'h0, tp});
		acc(4'h4, tp, sr);
		chk("a then b", 8'h01, {7'h0, tp});
		repeat (2) @(posedge mclk);
		rchk("a b flags", OFS_RUN_STATUS, 8'hC3);
		// begin trace: trigger word then seven more fill the capture
		arm(8'h40);
		acc(4'h0, tp, sr);
		chk("pre trig store", 8'h00, {7'h0, sr});
		acc(4'h8, tp, sr);
		chk("begin store", 8'h01, {7'h0, sr});
		repeat (7) acc(4'h0, tp, sr);
		repeat (2) @(posedge mclk);
		chk("full end", 8'h00, {7'h0, run_active});
		rchk("begin status", OFS_RUN_STATUS, 8'h88);
		// event only b, begin bit clear but ignored
		arm(8'h03);
		repeat (7) acc(4'h4, tp, sr);
		chk("event store", 8'h01, {7'h0, sr});
		chk("event armed", 8'h01, {7'h0, run_active});
		acc(4'h4, tp, sr);
		repeat (2) @(posedge mclk);
		rd(OFS_RUN_STATUS, rv);
		chk("event count", 8'h08, rv & 8'h2F);
		// a then event b
		arm(8'h04);
		acc(4'h4, tp, sr);
		chk("b before a", 8'h00, {7'h0, sr});
		acc(4'h8, tp, sr);
		acc(4'h4, tp, sr);
		chk("b after a", 8'h01, {7'h0, sr});
		wr(OFS_CONTROL, 8'h00);
		// tag type: flushed opcode drops the match, executed one triggers
		arm(8'h80);
		acc(4'h8, tp, sr);
		chk("tag no exec", 8'h00, {7'h0, tp});
		exec(1'b1, tp);
		exec(1'b0, tp);
		chk("tag flushed", 8'h00, {7'h0, tp});
		acc(4'h8, tp, sr);
		exec(1'b0, tp);
		chk("tag exec", 8'h01, {7'h0, tp});
		// clock enable low: a write in that cycle is frozen out
		@(posedge mclk);
		ce <= 1'b0;
		wr(OFS_IRQ_MASK, 8'h00);
		ce <= 1'b1;
		rchk("ce freeze", OFS_IRQ_MASK, IRQ_USED);
		complete_run();
	end
endmodule
`default_nettype wire
